// ==== logic/sfp_byte_fifo.sv ====
`timescale 1ns/1ps
module sfp_byte_fifo (
  // Clock and reset
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // Control
  input  wire logic                          flush,
  input  wire logic [sfp_pkg::SFP_CNT_W-1:0] cap,
  // Write side
  input  wire logic                          push,
  input  wire logic [7:0]                    wr_data,
  // Read side
  input  wire logic                          pop,
  output logic      [7:0]                    rd_data,
  // Fill state
  output logic      [sfp_pkg::SFP_CNT_W-1:0] count,
  output logic      [sfp_pkg::SFP_CNT_W-1:0] next_count
);
  import sfp_pkg::*;

  logic [7:0]           mem [SFP_DEPTH];
  logic [SFP_PTR_W-1:0] wr_ptr;
  logic [SFP_PTR_W-1:0] rd_ptr;
  logic                 do_push;
  logic                 do_pop;

  // Guard against overrun and underrun against the allotted capacity
  assign do_push = push && (count < cap);
  assign do_pop  = pop && (count != '0);
  assign rd_data = mem[rd_ptr];

  // Next fill level
  always_comb begin
    next_count = count;
    if (flush) begin
      next_count = '0;
    end else begin
      next_count = SFP_CNT_W'(count + SFP_CNT_W'(do_push) - SFP_CNT_W'(do_pop));
    end
  end

  // Pointers wrap inside the allotted capacity only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      count <= next_count;
      if (flush) begin
        wr_ptr <= '0;
        rd_ptr <= '0;
      end else begin
        if (do_push) begin
          wr_ptr <= (SFP_CNT_W'(wr_ptr) + 1'b1 >= cap) ? '0 : SFP_PTR_W'(wr_ptr + 1'b1);
        end
        if (do_pop) begin
          rd_ptr <= (SFP_CNT_W'(rd_ptr) + 1'b1 >= cap) ? '0 : SFP_PTR_W'(rd_ptr + 1'b1);
        end
      end
    end
  end

  // Byte storage
  always_ff @(posedge pclk) begin
    if (do_push && !flush) begin
      mem[wr_ptr] <= wr_data;
    end
  end

endmodule

// ==== logic/sfp_fifo_partition.sv ====
`timescale 1ns/1ps
module sfp_fifo_partition (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Transmit byte to shift logic
  output logic      [7:0]  tx_byte,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  // Receive byte from shift logic
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_valid,
  output logic             rx_ready,
  // Configuration seen by the channel
  output logic             fifo_active
);
  import sfp_pkg::*;

  // Software state
  logic                 fifo_enable_bit;
  sfp_dpx_t             dpx_sel;
  logic                 nine_bit_mode;
  logic                 rx_irq_condition_select;
  logic [1:0]           rx_fill_level;

  // Derived partition
  logic                 next_active;
  logic [SFP_CNT_W-1:0] next_rx_cap;
  logic [SFP_CNT_W-1:0] next_tx_cap;
  logic [SFP_CNT_W-1:0] rx_cap;
  logic [SFP_CNT_W-1:0] tx_cap;
  logic                 repartition;

  // Bus phase decode
  logic                 apb_act;
  logic                 apb_wr;
  logic                 apb_rd;
  logic [31:0]          rd_word;
  logic                 rd_err;

  // FIFO handshakes
  logic                 tx_push;
  logic                 tx_pop;
  logic [7:0]           tx_head;
  logic [SFP_CNT_W-1:0] tx_cnt;
  logic                 rx_push;
  logic                 rx_pop;
  logic [7:0]           rx_head;
  logic [SFP_CNT_W-1:0] rx_cnt;
  logic [SFP_CNT_W-1:0] rx_cnt_next;

  // Address match helper
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  // One access per transfer, completed on the cycle pready is high
  assign apb_act = psel && penable && !pready;
  assign apb_wr  = apb_act && pwrite;
  assign apb_rd  = apb_act && !pwrite;

  // Partition from enable, nine-bit mode and duplex selection
  always_comb begin
    next_active = fifo_enable_bit && !nine_bit_mode;
    next_rx_cap = SFP_CAP_SINGLE;
    next_tx_cap = SFP_CAP_SINGLE;
    if (next_active) begin
      case (dpx_sel)
        SFP_DPX_HALF_RX: begin
          next_rx_cap = SFP_CAP_ALL;
        end
        SFP_DPX_HALF_TX: begin
          next_tx_cap = SFP_CAP_ALL;
        end
        SFP_DPX_FULL: begin
          next_rx_cap = SFP_CAP_HALF;
          next_tx_cap = SFP_CAP_HALF;
        end
        default: begin
          next_rx_cap = SFP_CAP_SINGLE;
          next_tx_cap = SFP_CAP_SINGLE;
        end
      endcase
    end
  end

  // Any change of partition empties both FIFOs
  assign repartition = (next_rx_cap != rx_cap) || (next_tx_cap != tx_cap)
                       || (next_active != fifo_active);

  // Applied receive capacity
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_cap <= SFP_CAP_SINGLE;
    end else begin
      rx_cap <= next_rx_cap;
    end
  end

  // Applied transmit capacity, full depth only in half-duplex transmit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_cap <= SFP_CAP_SINGLE;
    end else begin
      tx_cap <= next_tx_cap;
    end
  end

  // FIFO in data path flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_active <= 1'b0;
    end else begin
      fifo_active <= next_active;
    end
  end

  // Control register, enable bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_enable_bit <= SFP_CTRL_RESET[SFP_CTRL_EN_BIT];
    end else if (apb_wr && hit(paddr, SFP_CTRL_OFS)) begin
      fifo_enable_bit <= pwdata[SFP_CTRL_EN_BIT];
    end
  end

  // Control register, duplex selection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dpx_sel <= sfp_dpx_t'(SFP_CTRL_RESET[SFP_CTRL_DPX_LSB +: 2]);
    end else if (apb_wr && hit(paddr, SFP_CTRL_OFS)) begin
      dpx_sel <= sfp_dpx_t'(pwdata[SFP_CTRL_DPX_LSB +: 2]);
    end
  end

  // Control register, nine-bit mode flag forces FIFO off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nine_bit_mode <= SFP_CTRL_RESET[SFP_CTRL_NINE_BIT];
    end else if (apb_wr && hit(paddr, SFP_CTRL_OFS)) begin
      nine_bit_mode <= pwdata[SFP_CTRL_NINE_BIT];
    end
  end

  // Receive FIFO config register, stored only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_irq_condition_select <= SFP_RFC_RESET[SFP_RFC_SEL_BIT];
      rx_fill_level           <= SFP_RFC_RESET[SFP_RFC_LVL_LSB +: 2];
    end else if (apb_wr && hit(paddr, SFP_RFC_OFS)) begin
      rx_irq_condition_select <= pwdata[SFP_RFC_SEL_BIT];
      rx_fill_level           <= pwdata[SFP_RFC_LVL_LSB +: 2];
    end
  end

  // Software pushes transmit bytes, pops receive bytes
  assign tx_push = apb_wr && hit(paddr, SFP_TXDATA_OFS) && (tx_cnt < tx_cap);
  assign rx_pop  = apb_rd && hit(paddr, SFP_RXDATA_OFS) && (rx_cnt != '0);

  // Read word of the addressed register
  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit(paddr, SFP_CTRL_OFS)) begin
      rd_word[SFP_CTRL_EN_BIT]             = fifo_enable_bit;
      rd_word[SFP_CTRL_DPX_LSB +: 2]       = dpx_sel;
      rd_word[SFP_CTRL_NINE_BIT]           = nine_bit_mode;
    end else if (hit(paddr, SFP_STATUS_OFS)) begin
      rd_word[SFP_ST_ACTIVE_BIT]             = fifo_active;
      rd_word[SFP_ST_RXCNT_LSB +: SFP_CNT_W] = rx_cnt;
      rd_word[SFP_ST_TXCNT_LSB +: SFP_CNT_W] = tx_cnt;
      rd_word[SFP_ST_RXCAP_LSB +: SFP_CNT_W] = rx_cap;
      rd_word[SFP_ST_TXCAP_LSB +: SFP_CNT_W] = tx_cap;
    end else if (hit(paddr, SFP_RXDATA_OFS)) begin
      rd_word[7:0] = (rx_cnt != '0) ? rx_head : 8'h00;
    end else if (hit(paddr, SFP_RFC_OFS)) begin
      rd_word[SFP_RFC_SEL_BIT]             = rx_irq_condition_select;
      rd_word[SFP_RFC_LVL_LSB +: 2]        = rx_fill_level;
    end
  end

  // Refusal of unmapped, wrong-direction or overfull access
  always_comb begin
    rd_err = 1'b1;
    if (hit(paddr, SFP_CTRL_OFS)) begin
      rd_err = 1'b0;
    end else if (hit(paddr, SFP_STATUS_OFS)) begin
      rd_err = pwrite;
    end else if (hit(paddr, SFP_TXDATA_OFS)) begin
      rd_err = !pwrite || (tx_cnt >= tx_cap);
    end else if (hit(paddr, SFP_RXDATA_OFS)) begin
      rd_err = pwrite;
    end else if (hit(paddr, SFP_RFC_OFS)) begin
      rd_err = 1'b0;
    end
  end

  // Completion strobe after one wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= apb_act;
    end
  end

  // Error flag, valid only with the completion strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= apb_act && rd_err;
    end
  end

  // Read data, zero outside the answer cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (apb_act) begin
      prdata <= rd_word;
    end else begin
      prdata <= 32'h0000_0000;
    end
  end

  // Transmit output stage feeding the shift logic
  assign tx_pop = (tx_cnt != '0) && (!tx_valid || tx_ready) && !repartition;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_valid <= 1'b0;
      tx_byte  <= 8'h00;
    end else if (tx_pop) begin
      tx_valid <= 1'b1;
      tx_byte  <= tx_head;
    end else if (tx_ready) begin
      tx_valid <= 1'b0;
    end
  end

  // Receive side accepts while room remains next cycle
  assign rx_push = rx_valid && rx_ready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_ready <= 1'b0;
    end else begin
      rx_ready <= !repartition && (rx_cnt_next < rx_cap);
    end
  end

  // Transmit storage
  sfp_byte_fifo u_tx_fifo (
    .pclk       (pclk),
    .presetn    (presetn),
    .flush      (repartition),
    .cap        (tx_cap),
    .push       (tx_push),
    .wr_data    (pwdata[7:0]),
    .pop        (tx_pop),
    .rd_data    (tx_head),
    .count      (tx_cnt),
    .next_count ()
  );

  // Receive storage
  sfp_byte_fifo u_rx_fifo (
    .pclk       (pclk),
    .presetn    (presetn),
    .flush      (repartition),
    .cap        (rx_cap),
    .push       (rx_push),
    .wr_data    (rx_byte),
    .pop        (rx_pop),
    .rd_data    (rx_head),
    .count      (rx_cnt),
    .next_count (rx_cnt_next)
  );

endmodule

// ==== logic/sfp_pkg.sv ====
package sfp_pkg;

  // Register byte offsets
  localparam logic [7:0] SFP_CTRL_OFS    = 8'h00;
  localparam logic [7:0] SFP_STATUS_OFS  = 8'h04;
  localparam logic [7:0] SFP_TXDATA_OFS  = 8'h08;
  localparam logic [7:0] SFP_RXDATA_OFS  = 8'h0C;
  localparam logic [7:0] SFP_RFC_OFS     = 8'h10;

  // Control register fields
  localparam int SFP_CTRL_EN_BIT   = 0;
  localparam int SFP_CTRL_DPX_LSB  = 1;
  localparam int SFP_CTRL_NINE_BIT = 3;
  localparam logic [31:0] SFP_CTRL_RESET = 32'h0000_0000;

  // Receive FIFO config fields
  localparam int SFP_RFC_CLR_BIT  = 7;
  localparam int SFP_RFC_SEL_BIT  = 6;
  localparam int SFP_RFC_LVL_LSB  = 0;
  localparam logic [31:0] SFP_RFC_RESET = 32'h0000_0000;

  // Status register fields
  localparam int SFP_ST_ACTIVE_BIT = 0;
  localparam int SFP_ST_RXCNT_LSB  = 4;
  localparam int SFP_ST_TXCNT_LSB  = 8;
  localparam int SFP_ST_RXCAP_LSB  = 12;
  localparam int SFP_ST_TXCAP_LSB  = 16;

  // Storage geometry
  localparam int SFP_DEPTH = 4;
  localparam int SFP_CNT_W = 3;
  localparam int SFP_PTR_W = 2;
  localparam logic [SFP_CNT_W-1:0] SFP_CAP_ALL    = 3'h4;
  localparam logic [SFP_CNT_W-1:0] SFP_CAP_HALF   = 3'h2;
  localparam logic [SFP_CNT_W-1:0] SFP_CAP_SINGLE = 3'h1;

  // Duplex selection
  typedef enum logic [1:0] {
    SFP_DPX_NONE    = 2'h0,
    SFP_DPX_HALF_RX = 2'h1,
    SFP_DPX_HALF_TX = 2'h2,
    SFP_DPX_FULL    = 2'h3
  } sfp_dpx_t;

endpackage

// ==== verification/sfp_chan_model.sv ====
`timescale 1ns/1ps
module sfp_chan_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Transmit side
  input  wire logic [7:0] tx_byte,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic       stall,
  // Receive side
  output logic      [7:0] rx_byte,
  output logic            rx_valid,
  input  wire logic       rx_ready
);
  logic [7:0] got  [64];
  logic [7:0] pend [64] = '{default: 8'hA5};
  int         ng;
  int         rd;
  int         wr;

  // Queue n rising bytes for the receive path
  task automatic put(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++) pend[wr + i] = b + 8'(i);
    wr <= wr + n;
  endtask

  // Released line shows the inverse of the last byte
  assign rx_valid = (rd != wr);
  assign rx_byte  = rx_valid ? pend[rd] : ~pend[(rd + 63) % 64];

  // Sink stalls on request, source advances on each take
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ready <= 1'b0;
      ng <= 0;
      rd <= 0;
    end else begin
      tx_ready <= !stall;
      if (tx_valid && tx_ready) begin
        got[ng] <= tx_byte;
        ng <= ng + 1;
      end
      if (rx_valid && rx_ready) rd <= rd + 1;
    end
  end
endmodule

// ==== verification/sfp_fifo_partition_asserts.sv ====
`timescale 1ns/1ps
module sfp_fifo_partition_asserts
  import sfp_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Links
  input wire logic [7:0]  tx_byte,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic [7:0]  rx_byte,
  input wire logic        rx_valid,
  input wire logic        rx_ready,
  input wire logic        fifo_active
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Access steps
  sequence acc_s; psel && penable && !pready; endsequence
  sequence ans_s; pready ##1 !pready; endsequence
  sequence ctl_s; psel && pwrite && paddr == SFP_CTRL_OFS; endsequence

  one_wait_a: assert property (acc_s |=> ans_s) else $error("pready late");
  err_pair_a: assert property (pslverr |-> pready) else $error("lone pslverr");
  rd_zero_a: assert property (!pready |-> prdata == 32'h0) else $error("stray prdata");
  bad_addr_a: assert property (acc_s and paddr > SFP_RFC_OFS |=> pslverr)
    else $error("unmapped ok");
  ro_write_a: assert property (pready && pwrite && (paddr == SFP_STATUS_OFS ||
    paddr == SFP_RXDATA_OFS) |-> pslverr) else $error("ro write ok");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
    else $error("tx byte lost");
  en_rise_a: assert property ($rose(fifo_active) |-> $past(psel && pwrite && paddr == SFP_CTRL_OFS))
    else $error("fifo on unasked");
  en_fall_a: assert property ($fell(fifo_active) |-> $past(psel && pwrite && paddr == SFP_CTRL_OFS))
    else $error("fifo off unasked");
endmodule

bind sfp_fifo_partition sfp_fifo_partition_asserts chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_byte(rx_byte),
  .rx_valid(rx_valid), .rx_ready(rx_ready), .fifo_active(fifo_active)
);

// ==== verification/test_sfp_fifo_partition.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
  $display("Error %0t: got %h want %h", $time, (a), (b)); end end
module test_sfp_fifo_partition;
  import sfp_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, stall;
  logic        tx_valid, tx_ready, rx_valid, rx_ready, fifo_active;
  logic [7:0]  paddr, tx_byte, rx_byte;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  rc, tc;
  int          error_cnt, comparisons, base;
  int          caps [3] = '{1, 4, 2};
  logic [31:0] ctls [3] = '{32'h0, 32'h5, 32'h7};

  sfp_fifo_partition dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_byte(tx_byte), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .fifo_active(fifo_active));
  sfp_chan_model model_u (.pclk(pclk), .presetn(presetn), .tx_byte(tx_byte),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .stall(stall), .rx_byte(rx_byte),
    .rx_valid(rx_valid), .rx_ready(rx_ready));

  // One APB transfer, then error compared, and read data too on reads expecting no error
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic ee, input logic [31:0] ed);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    `CHK(er, ee)
    if (!w && !ee) `CHK(rd, ed)
  endtask

  // Verdict
  task automatic finish_test();
    $display("Mismatches %0d of %0d checks", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Clock and watchdog
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    finish_test();
  end

  // Test sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, stall} = '0;
    stall = 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    `CHK(rx_ready, 1'b1)
    xfer(0, SFP_CTRL_OFS, 0, 0, SFP_CTRL_RESET);
    xfer(0, SFP_RFC_OFS, 0, 0, SFP_RFC_RESET);
    xfer(0, SFP_STATUS_OFS, 0, 0, 32'h11000);
    xfer(1, SFP_RFC_OFS, 32'hFF, 0, 0);
    xfer(0, SFP_RFC_OFS, 0, 0, 32'h43);
    xfer(0, 8'h20, 0, 1, 0);
    xfer(1, SFP_STATUS_OFS, 0, 1, 0);
    xfer(0, SFP_TXDATA_OFS, 0, 1, 0);
    for (int d = 0; d < 4; d++) begin
      rc = (d == 1) ? 3'h4 : (d == 3) ? 3'h2 : 3'h1;
      tc = (d == 2) ? 3'h4 : (d == 3) ? 3'h2 : 3'h1;
      xfer(1, SFP_CTRL_OFS, 2 * d + 1, 0, 0);
      xfer(0, SFP_STATUS_OFS, 0, 0, {13'h0, tc, 1'b0, rc, 12'h001});
      `CHK(fifo_active, 1'b1)
    end
    xfer(1, SFP_CTRL_OFS, 32'hF, 0, 0);
    xfer(0, SFP_STATUS_OFS, 0, 0, 32'h11000);
    `CHK(fifo_active, 1'b0)
    // Fill transmit path while stalled, then drain in order
    for (int k = 0; k < 3; k++) begin
      xfer(1, SFP_CTRL_OFS, ctls[k], 0, 0);
      base = model_u.ng;
      for (int i = 0; i <= caps[k]; i++) xfer(1, SFP_TXDATA_OFS, 32'hA0 + i, 0, 0);
      xfer(1, SFP_TXDATA_OFS, 32'hEE, 1, 0);
      stall <= 1'b0;
      for (int i = 0; i <= caps[k]; i++) begin
        while (model_u.ng <= base + i) @(posedge pclk);
        `CHK(model_u.got[base + i], 8'(8'hA0 + i))
      end
      stall <= 1'b1;
    end
    // Receive path fills to four, then refuses
    xfer(1, SFP_CTRL_OFS, 32'h3, 0, 0);
    model_u.put(8'h50, 5);
    while (model_u.rd < 4) @(posedge pclk);
    repeat (2) @(posedge pclk);
    `CHK(rx_ready, 1'b0)
    for (int i = 0; i < 5; i++) xfer(0, SFP_RXDATA_OFS, 0, 0, 32'h50 + i);
    xfer(0, SFP_RXDATA_OFS, 0, 0, 0);
    finish_test();
  end
endmodule
